// File: mrm_pkg.sv
// Package: register map, field layouts and timing constants of the readout map
// ============================================================================
// Notes on behaviour
// - Raw register shows unprocessed measured input
// - Cold-junction register reports terminal temperature
// - Secondary register copies lower display value
// - Free space in kB, -1 when unmounted
// - Capacity in kB, -1 when unmounted
// - Register exposes analog output drive value
// - Min/max dates kept as YYMMDD numbers
// - Min/max times kept as HH.MMSS numbers
// - Processed value after characteristic then math
// - Status words mirrored as float registers
// - 32-bit values also readable as 16-bit pairs
// - Writing 1 to reinit restarts network
// - DHCP address (zero after reinit without lease) or default address used
// - Link LED lit only at 100 Mbit/s
// - Activity LED steady idle, flickers on traffic
package mrm_pkg;
  // ==========================================================================
  // Register numbers (32-bit range)
  localparam logic [15:0] REG_IDENT      = 16'h1d4c;
  localparam logic [15:0] REG_RAW        = 16'h1d56;
  localparam logic [15:0] REG_COLD       = 16'h1d57;
  localparam logic [15:0] REG_SECOND     = 16'h1d58;
  localparam logic [15:0] REG_FREE       = 16'h1d59;
  localparam logic [15:0] REG_CAPACITY   = 16'h1d5a;
  localparam logic [15:0] REG_ANALOG     = 16'h1d5d;
  localparam logic [15:0] REG_MIN_DATE   = 16'h1d63;
  localparam logic [15:0] REG_MAX_DATE   = 16'h1d64;
  localparam logic [15:0] REG_MIN_TIME   = 16'h1d65;
  localparam logic [15:0] REG_MAX_TIME   = 16'h1d66;
  localparam logic [15:0] REG_PROCESSED  = 16'h1d67;
  localparam logic [15:0] REG_STAT1_F    = 16'h1d6e;
  localparam logic [15:0] REG_STAT2_F    = 16'h1d6f;
  localparam logic [15:0] REG_MAP_FIRST  = 16'h1d4c;
  localparam logic [15:0] REG_MAP_LAST   = 16'h1d71;
  // 16-bit mirror ranges, two registers per 32-bit value
  localparam logic [15:0] MIRROR_A_BASE  = 16'h1770;
  localparam logic [15:0] MIRROR_B_BASE  = 16'h1b58;
  // Control registers
  localparam logic [15:0] REG_REINIT     = 16'h1003;
  localparam logic [15:0] REG_DEFAULTS   = 16'h0ff0;
  localparam logic [15:0] REG_DHCP       = 16'h1004;
  localparam logic [15:0] REG_NET_STATUS = 16'h1005;
  localparam logic [31:0] CMD_ONE        = 32'h0000_0001;
  localparam logic [31:0] MEDIA_ERROR    = 32'hffff_ffff;
  // Arbitrary identification value
  localparam logic [31:0] IDENT_VALUE    = 32'h0000_00a5;
  localparam logic [31:0] DEFAULT_IP     = 32'hc0a8_011e;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam logic [31:0] IP_ZERO        = 32'h0000_0000;
  // ==========================================================================
  // Timing
  localparam int CLOCK_HZ         = 50_000_000;
  localparam int FLICKER_US       = 20;
  localparam int FLICKER_CYCLES   = CLOCK_HZ / 1_000_000 * FLICKER_US;
  localparam int REINIT_US        = 10;
  localparam int REINIT_CYCLES    = CLOCK_HZ / 1_000_000 * REINIT_US;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  typedef struct packed {
    logic [31:0] raw;
    logic [31:0] cold;
    logic [31:0] second;
    logic [31:0] free_kb;
    logic [31:0] capacity_kb;
    logic        media_ok;
    logic [31:0] analog;
    logic [31:0] min_date;
    logic [31:0] max_date;
    logic [31:0] min_time;
    logic [31:0] max_time;
    logic [31:0] processed;
    logic [31:0] stat1_f;
    logic [31:0] stat2_f;
  } mrm_meas_s;

  typedef struct packed {
    logic        up;
    logic        speed_100;
    logic        traffic;
    logic        dhcp_bound;
    logic [31:0] dhcp_ip;
  } mrm_link_s;
endpackage

// File: mrm_readout_map.sv
// Module: readout map with network controls and indicator drive
`timescale 1ns/1ps
module mrm_readout_map (
  input  wire logic               clock_i,
  input  wire logic               reset_i,
  input  wire mrm_pkg::mrm_meas_s meas_i,
  input  wire mrm_pkg::mrm_link_s link_i,
  input  wire logic               rd_i,
  input  wire logic               wr_i,
  input  wire logic [15:0]        addr_i,
  input  wire logic [31:0]        wdata_i,
  output logic [31:0]             rdata_o,
  output logic                    rvalid_o,
  output logic                    net_reinit_o,
  output logic                    net_defaults_o,
  output logic                    dhcp_enable_o,
  output logic [31:0]             ip_addr_o,
  output logic                    led_link_o,
  output logic                    led_activity_o
);
  // ==========================================================================
  // Input synchronisers for link status (three stages, 2nd/3rd agree)
  logic [2:0] up_sync_reg;
  logic [2:0] spd_sync_reg;
  logic [2:0] trf_sync_reg;
  logic       up_reg;
  logic       spd_reg;
  logic       trf_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      up_sync_reg  <= 3'h0;
      spd_sync_reg <= 3'h0;
      trf_sync_reg <= 3'h0;
    end else begin
      up_sync_reg  <= {up_sync_reg[1:0], link_i.up};
      spd_sync_reg <= {spd_sync_reg[1:0], link_i.speed_100};
      trf_sync_reg <= {trf_sync_reg[1:0], link_i.traffic};
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      up_reg  <= 1'b0;
      spd_reg <= 1'b0;
      trf_reg <= 1'b0;
    end else begin
      if (up_sync_reg[1] == up_sync_reg[2]) up_reg <= up_sync_reg[2];
      if (spd_sync_reg[1] == spd_sync_reg[2]) spd_reg <= spd_sync_reg[2];
      if (trf_sync_reg[1] == trf_sync_reg[2]) trf_reg <= trf_sync_reg[2];
    end
  end

  // ==========================================================================
  // Address decode: 32-bit index, or 16-bit mirror half
  function automatic logic [16:0] mirror_index(input logic [15:0] a);
    logic [15:0] off;
    off = 16'h0000;
    if (a >= mrm_pkg::MIRROR_B_BASE && a < mrm_pkg::REG_MAP_FIRST) begin
      off = a - mrm_pkg::MIRROR_B_BASE;
    end else if (a >= mrm_pkg::MIRROR_A_BASE &&
                 a < mrm_pkg::MIRROR_B_BASE) begin
      off = a - mrm_pkg::MIRROR_A_BASE;
    end
    return {off[0], 16'(mrm_pkg::REG_MAP_FIRST + {1'b0, off[15:1]})};
  endfunction

  function automatic logic is_mirror(input logic [15:0] a);
    return a >= mrm_pkg::MIRROR_A_BASE && a < mrm_pkg::REG_MAP_FIRST &&
           a[0] == 1'b0 || a >= mrm_pkg::MIRROR_A_BASE &&
           a < mrm_pkg::REG_MAP_FIRST;
  endfunction

  // ==========================================================================
  // Control registers
  logic        dhcp_reg;
  logic        reinit_reg;
  logic        defaults_reg;
  logic [31:0] ip_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reinit_reg   <= 1'b0;
      defaults_reg <= 1'b0;
    end else begin
      reinit_reg   <= wr_i && addr_i == mrm_pkg::REG_REINIT &&
                      wdata_i == mrm_pkg::CMD_ONE;
      defaults_reg <= wr_i && addr_i == mrm_pkg::REG_DEFAULTS &&
                      wdata_i == mrm_pkg::CMD_ONE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dhcp_reg <= 1'b0;
    end else if (defaults_reg) begin
      dhcp_reg <= 1'b0;
    end else if (wr_i && addr_i == mrm_pkg::REG_DHCP) begin
      dhcp_reg <= wdata_i[0];
    end
  end

  // Address follows DHCP lease (zero on reinit without lease), else default address
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ip_reg <= mrm_pkg::DEFAULT_IP;
    end else if (reinit_reg || defaults_reg) begin
      if (dhcp_reg && !defaults_reg) begin
        ip_reg <= link_i.dhcp_bound ? link_i.dhcp_ip
                                    : mrm_pkg::IP_ZERO;
      end else begin
        ip_reg <= mrm_pkg::DEFAULT_IP;
      end
    end else if (dhcp_reg && link_i.dhcp_bound) begin
      ip_reg <= link_i.dhcp_ip;
    end
  end

  assign net_reinit_o   = reinit_reg;
  assign net_defaults_o = defaults_reg;
  assign dhcp_enable_o  = dhcp_reg;
  assign ip_addr_o      = ip_reg;

  // ==========================================================================
  // Read multiplexer
  function automatic logic [31:0] word_at(input logic [15:0] idx,
                                         input mrm_pkg::mrm_meas_s m);
    logic [31:0] v;
    v = mrm_pkg::ZERO_WORD;
    if (idx == mrm_pkg::REG_IDENT) v = mrm_pkg::IDENT_VALUE;
    else if (idx == mrm_pkg::REG_RAW) v = m.raw;
    else if (idx == mrm_pkg::REG_COLD) v = m.cold;
    else if (idx == mrm_pkg::REG_SECOND) v = m.second;
    else if (idx == mrm_pkg::REG_FREE)
      v = m.media_ok ? m.free_kb : mrm_pkg::MEDIA_ERROR;
    else if (idx == mrm_pkg::REG_CAPACITY)
      v = m.media_ok ? m.capacity_kb : mrm_pkg::MEDIA_ERROR;
    else if (idx == mrm_pkg::REG_ANALOG) v = m.analog;
    else if (idx == mrm_pkg::REG_MIN_DATE) v = m.min_date;
    else if (idx == mrm_pkg::REG_MAX_DATE) v = m.max_date;
    else if (idx == mrm_pkg::REG_MIN_TIME) v = m.min_time;
    else if (idx == mrm_pkg::REG_MAX_TIME) v = m.max_time;
    else if (idx == mrm_pkg::REG_PROCESSED) v = m.processed;
    else if (idx == mrm_pkg::REG_STAT1_F) v = m.stat1_f;
    else if (idx == mrm_pkg::REG_STAT2_F) v = m.stat2_f;
    return v;
  endfunction

  logic [16:0] mir;
  logic [31:0] mword;
  logic [31:0] rdata_next;

  always_comb begin
    mir   = mirror_index(addr_i);
    mword = word_at(mir[15:0], meas_i);
    if (is_mirror(addr_i)) begin
      rdata_next = mir[16] ? {16'h0000, mword[15:0]}
                           : {16'h0000, mword[31:16]};
    end else if (addr_i >= mrm_pkg::REG_MAP_FIRST &&
                 addr_i <= mrm_pkg::REG_MAP_LAST) begin
      rdata_next = word_at(addr_i, meas_i);
    end else if (addr_i == mrm_pkg::REG_DHCP) begin
      rdata_next = {31'h0, dhcp_reg};
    end else if (addr_i == mrm_pkg::REG_NET_STATUS) begin
      rdata_next = {29'h0, trf_reg, spd_reg, up_reg};
    end else begin
      rdata_next = mrm_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o  <= mrm_pkg::ZERO_WORD;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) rdata_o <= rdata_next;
    end
  end

  // ==========================================================================
  // Indicator LEDs
  logic [15:0] lfsr_reg;
  logic [15:0] flick_cnt_reg;
  logic        act_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      led_link_o <= 1'b0;
    end else begin
      led_link_o <= up_reg && spd_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lfsr_reg      <= mrm_pkg::LFSR_SEED;
      flick_cnt_reg <= 16'h0000;
      act_reg       <= 1'b1;
    end else if (!trf_reg) begin
      flick_cnt_reg <= 16'h0000;
      act_reg       <= 1'b1;
    end else if (flick_cnt_reg == 16'(mrm_pkg::FLICKER_CYCLES - 1)) begin
      flick_cnt_reg <= 16'h0000;
      lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^
                  (lfsr_reg[0] ? mrm_pkg::LFSR_TAPS : 16'h0000);
      act_reg <= lfsr_reg[0];
    end else begin
      flick_cnt_reg <= flick_cnt_reg + 16'h0001;
    end
  end

  assign led_activity_o = act_reg;

  // ==========================================================================
  // Checks: register reads
  a_raw_read: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_RAW
    |=> rvalid_o && rdata_o == $past(meas_i.raw))
    else $error("raw value mismatch");
  a_cold_read: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_COLD
    |=> rdata_o == $past(meas_i.cold))
    else $error("cold junction mismatch");
  a_free_read: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_FREE && meas_i.media_ok
    |=> rdata_o == $past(meas_i.free_kb))
    else $error("free space mismatch");
  a_free_error: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_FREE && !meas_i.media_ok
    |=> rdata_o == mrm_pkg::MEDIA_ERROR)
    else $error("free space not -1");
  a_cap_error: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_CAPACITY && !meas_i.media_ok
    |=> rdata_o == mrm_pkg::MEDIA_ERROR)
    else $error("capacity not -1");
  a_proc_read: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_PROCESSED
    |=> rdata_o == $past(meas_i.processed))
    else $error("processed mismatch");
  a_reserved_zero: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_MAP_LAST
    |=> rdata_o == mrm_pkg::ZERO_WORD)
    else $error("reserved not zero");
  a_read_valid: assert property (@(posedge clock_i)
    disable iff (reset_i)
    rd_i |=> rvalid_o)
    else $error("read not answered");

  // ==========================================================================
  // Checks: network controls and indicators
  a_reinit_pulse: assert property (@(posedge clock_i)
    disable iff (reset_i)
    wr_i && addr_i == mrm_pkg::REG_REINIT && wdata_i == mrm_pkg::CMD_ONE
    |=> net_reinit_o)
    else $error("reinit not pulsed");
  a_reinit_only_one: assert property (@(posedge clock_i)
    disable iff (reset_i)
    net_reinit_o |-> $past(wr_i) && $past(wdata_i) == mrm_pkg::CMD_ONE &&
    $past(addr_i) == mrm_pkg::REG_REINIT)
    else $error("reinit without write of one");
  a_dhcp_lease: assert property (@(posedge clock_i)
    disable iff (reset_i)
    dhcp_enable_o && link_i.dhcp_bound && !net_reinit_o && !net_defaults_o
    |=> ip_addr_o == $past(link_i.dhcp_ip))
    else $error("address not taken from lease");
  a_default_ip: assert property (@(posedge clock_i)
    disable iff (reset_i)
    net_defaults_o
    |=> ip_addr_o == mrm_pkg::DEFAULT_IP && !dhcp_enable_o)
    else $error("defaults not restored");
  a_link_led: assert property (@(posedge clock_i)
    disable iff (reset_i)
    led_link_o |-> $past(up_reg) && $past(spd_reg))
    else $error("link led without 100M link");
  a_link_lit: assert property (@(posedge clock_i)
    disable iff (reset_i)
    up_reg && spd_reg |=> led_link_o)
    else $error("link led dark on 100M link");
  a_act_idle: assert property (@(posedge clock_i)
    disable iff (reset_i)
    !trf_reg [*2] |-> led_activity_o)
    else $error("activity led dark while idle");

  // ==========================================================================
  // Coverage of the main scenarios
  c_reinit: cover property (@(posedge clock_i) disable iff (reset_i)
    net_reinit_o);
  c_mirror_read: cover property (@(posedge clock_i) disable iff (reset_i)
    rd_i && is_mirror(addr_i));
  c_flicker: cover property (@(posedge clock_i) disable iff (reset_i)
    trf_reg && !led_activity_o);
  c_link_up: cover property (@(posedge clock_i) disable iff (reset_i)
    led_link_o);
  c_media_error: cover property (@(posedge clock_i) disable iff (reset_i)
    rd_i && addr_i == mrm_pkg::REG_FREE && !meas_i.media_ok);
endmodule

// File: mrm_master_model.sv
// Register master model driving the map's read and write strobes
`timescale 1ns/1ps
module mrm_master_model (
  input  wire logic        clock_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [15:0]      addr_o,
  output logic [31:0]      wdata_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
  end
  // One strobe cycle per access; idle bus shows inverted values
  task automatic access(input logic wr, input logic [15:0] addr,
                        input logic [31:0] data,
                        output logic [31:0] rd_data, output logic ok);
    @(posedge clock_i);
    #1;
    rd_o = ~wr;
    wr_o = wr;
    addr_o = addr;
    wdata_o = data;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~addr;
    wdata_o = ~data;
    rd_data = rdata_i;
    ok = wr | (rvalid_i === 1'b1);
  endtask
endmodule

// File: test_measurement_readout_map_eth_ctrl.sv
// Self-checking bench for the readout map and network controls
`timescale 1ns/1ps
module test_measurement_readout_map_eth_ctrl;
  // ==========================================================================
  // Signals
  logic               clock_i;
  logic               reset_i;
  mrm_pkg::mrm_meas_s meas;
  mrm_pkg::mrm_link_s link;
  logic               rd;
  logic               wr;
  logic [15:0]        addr;
  logic [31:0]        wdata;
  logic [31:0]        rdata;
  logic               rvalid;
  logic               reinit;
  logic               defaults;
  logic               dhcp_en;
  logic [31:0]        ip;
  logic               led_link;
  logic               led_act;
  int                 n_fail;
  int                 checked;
  int                 cycles;
  int                 lows;

  mrm_readout_map i_mrm_readout_map (
    .clock_i(clock_i), .reset_i(reset_i), .meas_i(meas), .link_i(link),
    .rd_i(rd), .wr_i(wr), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata), .rvalid_o(rvalid), .net_reinit_o(reinit),
    .net_defaults_o(defaults), .dhcp_enable_o(dhcp_en), .ip_addr_o(ip),
    .led_link_o(led_link), .led_activity_o(led_act)
  );
  mrm_master_model i_mrm_master_model (
    .clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    i_mrm_master_model.access(1'b0, a, 32'h0000_0000, d, ok);
    chk($sformatf("rvalid %h", a), 32'h0000_0001, {31'h0, ok});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        ok;
    i_mrm_master_model.access(1'b1, a, v, d, ok);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    chk("rdata", 32'h0000_0000, rdata);
    chk("rvalid", 32'h0000_0000, {31'h0, rvalid});
    chk("dhcp", 32'h0000_0000, {31'h0, dhcp_en});
    chk("ip", mrm_pkg::DEFAULT_IP, ip);
    chk("link led", 32'h0000_0000, {31'h0, led_link});
    chk("act led", 32'h0000_0001, {31'h0, led_act});
  endtask
  task automatic test_values();
    rd_chk(mrm_pkg::REG_IDENT, mrm_pkg::IDENT_VALUE);
    rd_chk(mrm_pkg::REG_RAW, meas.raw);
    rd_chk(mrm_pkg::REG_COLD, meas.cold);
    rd_chk(mrm_pkg::REG_SECOND, meas.second);
    rd_chk(mrm_pkg::REG_FREE, meas.free_kb);
    rd_chk(mrm_pkg::REG_CAPACITY, meas.capacity_kb);
    rd_chk(mrm_pkg::REG_ANALOG, meas.analog);
    rd_chk(mrm_pkg::REG_MIN_DATE, meas.min_date);
    rd_chk(mrm_pkg::REG_MAX_DATE, meas.max_date);
    rd_chk(mrm_pkg::REG_MIN_TIME, meas.min_time);
    rd_chk(mrm_pkg::REG_MAX_TIME, meas.max_time);
    rd_chk(mrm_pkg::REG_PROCESSED, meas.processed);
    rd_chk(mrm_pkg::REG_STAT1_F, meas.stat1_f);
    rd_chk(mrm_pkg::REG_STAT2_F, meas.stat2_f);
  endtask
  task automatic test_media_mirror();
    meas.media_ok = 1'b0;
    rd_chk(mrm_pkg::REG_FREE, mrm_pkg::MEDIA_ERROR);
    rd_chk(mrm_pkg::REG_CAPACITY, mrm_pkg::MEDIA_ERROR);
    meas.media_ok = 1'b1;
    rd_chk(16'h1784, {16'h0000, meas.raw[31:16]});
    rd_chk(16'h1785, {16'h0000, meas.raw[15:0]});
    rd_chk(16'h1b6d, {16'h0000, meas.raw[15:0]});
  endtask
  task automatic test_refuse();
    wr_reg(mrm_pkg::REG_RAW, 32'hdead_beef);
    rd_chk(mrm_pkg::REG_RAW, meas.raw);
    rd_chk(16'h1d5b, 32'h0000_0000);
    rd_chk(16'h1d6a, 32'h0000_0000);
    rd_chk(mrm_pkg::REG_MAP_LAST, 32'h0000_0000);
    wr_reg(mrm_pkg::REG_REINIT, 32'h0000_0002);
    chk("reinit bad", 32'h0000_0000, {31'h0, reinit});
  endtask
  task automatic test_network();
    wr_reg(mrm_pkg::REG_DHCP, 32'h0000_0001);
    chk("dhcp on", 32'h0000_0001, {31'h0, dhcp_en});
    rd_chk(mrm_pkg::REG_DHCP, 32'h0000_0001);
    wr_reg(mrm_pkg::REG_REINIT, mrm_pkg::CMD_ONE);
    chk("reinit", 32'h0000_0001, {31'h0, reinit});
    tick(1);
    chk("reinit end", 32'h0000_0000, {31'h0, reinit});
    chk("ip no lease", mrm_pkg::IP_ZERO, ip);
    link.dhcp_ip = 32'h0a00_0005;
    link.dhcp_bound = 1'b1;
    tick(3);
    chk("ip lease", 32'h0a00_0005, ip);
    wr_reg(mrm_pkg::REG_DEFAULTS, mrm_pkg::CMD_ONE);
    chk("defaults", 32'h0000_0001, {31'h0, defaults});
    tick(2);
    chk("dhcp off", 32'h0000_0000, {31'h0, dhcp_en});
    chk("ip default", mrm_pkg::DEFAULT_IP, ip);
  endtask
  task automatic test_leds();
    link.up = 1'b1;
    link.speed_100 = 1'b1;
    tick(8);
    chk("link 100", 32'h0000_0001, {31'h0, led_link});
    rd_chk(mrm_pkg::REG_NET_STATUS, 32'h0000_0003);
    link.speed_100 = 1'b0;
    tick(8);
    chk("link 10", 32'h0000_0000, {31'h0, led_link});
    link.up = 1'b0;
    link.speed_100 = 1'b1;
    tick(8);
    chk("link down", 32'h0000_0000, {31'h0, led_link});
    lows = 0;
    for (int i = 0; i < 200; i++) begin
      tick(1);
      lows += (led_act !== 1'b1);
    end
    chk("act idle", 32'h0000_0000, lows);
    link.traffic = 1'b1;
    lows = 0;
    for (int i = 0; i < 3000; i++) begin
      tick(1);
      lows += (led_act === 1'b0);
    end
    chk("act flicker", 32'h0000_0001, {31'h0, lows > 0});
    link = '0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    cycles = 0;
    reset_i = 1'b1;
    link = '0;
    meas = '0;
    meas.raw = 32'h1234_5678;
    meas.cold = 32'h0000_0017;
    meas.second = 32'h0000_2222;
    meas.free_kb = 32'h0000_3333;
    meas.capacity_kb = 32'h0000_4444;
    meas.media_ok = 1'b1;
    meas.analog = 32'h0000_5555;
    meas.min_date = 32'h0001_fd40;
    meas.max_date = 32'h0001_fd41;
    meas.min_time = 32'h0000_6666;
    meas.max_time = 32'h0000_7777;
    meas.processed = 32'h0000_8888;
    meas.stat1_f = 32'h3f80_0000;
    meas.stat2_f = 32'h4000_0000;
    tick(5);
    reset_i = 1'b0;
    test_reset();
    test_values();
    test_media_mirror();
    test_refuse();
    test_network();
    test_leds();
    complete_run();
  end
endmodule
